// [core/tpwfs_cmp_filter.v]
// Purpose: Synchronise and filter one comparator output
// Assumes: raw input is asynchronous to CLK
// Notes:   Output moves only when all recent samples agree
`timescale 1ns/1ps
`default_nettype none
`include "tpwfs_defines.vh"

module tpwfs_cmp_filter (
  input  wire clk,     // System clock
  input  wire rst_n,   // Synchronous reset, active low
  input  wire raw_i,   // Comparator output, asynchronous
  output reg  lvl_o    // Filtered level
);

  reg                          s1_q;
  reg                          s2_q;
  reg [`TPWFS_FILT_SAMPLES-2:0] hist_q;

  always @(posedge clk) begin
    if (!rst_n) begin
      s1_q   <= 1'b0;
      s2_q   <= 1'b0;
      hist_q <= {(`TPWFS_FILT_SAMPLES-1){1'b0}};
      lvl_o  <= 1'b0;
    end else begin
      s1_q   <= raw_i;
      s2_q   <= s1_q;
      hist_q <= {hist_q[`TPWFS_FILT_SAMPLES-3:0], s2_q};
      if (&{hist_q, s2_q}) begin
        lvl_o <= 1'b1;
      end else if (~|{hist_q, s2_q}) begin
        lvl_o <= 1'b0;
      end
    end
  end

endmodule // tpwfs_cmp_filter
`default_nettype wire

// [core/tpwfs_defines.vh]
// Purpose: Constants for the three-phase PWM generator with fault latch and delay trigger
// Assumes: 25 MHz CLK; classic Wishbone, 32-bit data, byte addresses
// Notes:   Overview list below; offsets are byte addresses of aligned words
//
// Overview of operation
// - Channels paired 0+1, 2+3, 4+5, complementary
// - Channels 6 and 7 always masked off
// - Faults latch on every pair; software clears
// - Carrier frequency setting, default 10 kHz
// - Dead-time on every pair, from setting
// - Trigger pulse on every counter initialisation
// - Fault 0 over-temperature, fault 1 over-current
// - Fault inputs are active high
// - Counter runs on undivided system clock
// - Counting continues while debugger halts processor
// - Comparators use 6-bit threshold reference
// - Comparator level changes after four agreeing samples
// - Delay block starts on trigger, flags sequence errors
// - One sync trigger per period, at reload
// - Minimum gap between pair off and on
`ifndef TPWFS_DEFINES_VH
`define TPWFS_DEFINES_VH

// Timing
`define TPWFS_CLK_HZ        25000000
`define TPWFS_PWM_FREQ_HZ   10000
`define TPWFS_PERIOD_CYC    (`TPWFS_CLK_HZ / `TPWFS_PWM_FREQ_HZ)
`define TPWFS_DEADTIME_NS   1000
`define TPWFS_DEADTIME_CYC  ((`TPWFS_DEADTIME_NS * (`TPWFS_CLK_HZ / 1000000) + 999) / 1000)
`define TPWFS_FILT_SAMPLES  4

// Register offsets
`define TPWFS_OFS_CTRL      8'h00
`define TPWFS_OFS_PERIOD    8'h04
`define TPWFS_OFS_DEADTIME  8'h08
`define TPWFS_OFS_DUTY_A    8'h0C
`define TPWFS_OFS_DUTY_B    8'h10
`define TPWFS_OFS_DUTY_C    8'h14
`define TPWFS_OFS_OUTPUT_MASK_SETTING   8'h18
`define TPWFS_OFS_THRESH    8'h1C
`define TPWFS_OFS_STATUS    8'h20
`define TPWFS_OFS_IRQ_STAT  8'h24
`define TPWFS_OFS_IRQ_MASK  8'h28
`define TPWFS_OFS_TRIG_DLY  8'h2C

// Field positions
`define TPWFS_CTRL_RUN      0
`define TPWFS_CTRL_FCLR     1
`define TPWFS_CTRL_DTE      2
`define TPWFS_IRQ_OT        0
`define TPWFS_IRQ_OC        1
`define TPWFS_IRQ_SEQ       2
`define TPWFS_IRQ_RLD       3

// Reset values
`define TPWFS_OUTPUT_MASK_SETTING_RST   8'hC0
`define TPWFS_OUTPUT_MASK_SETTING_FIX   8'hC0
`define TPWFS_THRESH_RST    6'h20
`define TPWFS_DUTY_RST      16'h0000
`define TPWFS_TRIG_DLY_RST  16'h0010

`endif

// [core/tpwfs_top.v]
// Purpose: Three-phase complementary PWM with dead-time, fault latch and sync trigger
// Assumes: one 25 MHz clock; Wishbone classic slave; comparator outputs are async pins
// Notes:   Outputs PWM_OUT[0..5] = A top, A bottom, B top, B bottom, C top, C bottom
//
// The Wishbone register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tpwfs_defines.vh"

module tpwfs_top (
  input  wire        CLK,        // System clock
  input  wire        RST_N,      // Synchronous reset, active low
  input  wire        WB_CYC_I,   // Wishbone cycle
  input  wire        WB_STB_I,   // Wishbone strobe
  input  wire        WB_WE_I,    // Wishbone write enable
  input  wire [7:0]  WB_ADR_I,   // Byte address
  input  wire [3:0]  WB_SEL_I,   // Byte lanes
  input  wire [31:0] WB_DAT_I,   // Write data
  output reg  [31:0] WB_DAT_O,   // Read data
  output reg         WB_ACK_O,   // Acknowledge
  input  wire        CMP_OT_I,   // Over-temperature comparator, high = fault
  input  wire        CMP_OC_I,   // Over-current comparator, high = fault
  input  wire        DBG_HALT_I, // Processor halted by debugger
  output reg  [5:0]  PWM_OUT,    // Gate drive outputs
  output reg  [5:0]  DAC_OT,     // Over-temperature threshold code
  output reg  [5:0]  DAC_OC,     // Over-current threshold code
  output reg         SYNC_TRIG,  // Reload sync pulse to delay block
  output reg         ADC_TRIG,   // Delayed converter trigger pulse
  output reg         IRQ         // Level interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  reg        run_q;
  reg        dte_q;
  reg [15:0] per_q;
  reg [15:0] per_act_q;
  reg [15:0] cnt_q;
  reg [9:0]  dt_q;
  reg [15:0] duty_q [0:2];
  reg [15:0] duty_act_q [0:2];
  reg [7:0]  mask_q;
  reg [15:0] dly_q;
  reg [15:0] dcnt_q;
  reg        dbusy_q;
  reg [1:0]  flt_q;
  reg [3:0]  ist_q;
  reg [3:0]  imsk_q;
  reg [2:0]  hs_q;
  reg [2:0]  ls_q;
  reg [9:0]  dtc_q [0:2];
  reg        dbg1_q;
  reg        dbg2_q;
  reg [2:0]  ref_d;
  reg [31:0] rdata;
  wire [1:0] cmp_f;
  wire [7:0] wadr;
  wire       wr;
  wire       rd;
  wire [31:0] wdat;
  wire [31:0] w1c;
  wire       fclr;
  wire       reload;
  wire       seq_err;
  wire [3:0] ev;
  integer    i, j, k, m, n;

  // Reset values are cut from the 32-bit timing expressions on purpose
  localparam [31:0] PER_RST = `TPWFS_PERIOD_CYC;
  localparam [31:0] DT_RST  = `TPWFS_DEADTIME_CYC;

  function [31:0] lanes;
    input [3:0] sel;
    begin
      lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    end
  endfunction

  function hit;
    input [7:0] adr;
    input [7:0] ofs;
    begin
      hit = (adr == ofs);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Comparator filters

  tpwfs_cmp_filter u_flt_ot (
    .clk   (CLK),
    .rst_n (RST_N),
    .raw_i (CMP_OT_I),
    .lvl_o (cmp_f[0])
  );

  tpwfs_cmp_filter u_flt_oc (
    .clk   (CLK),
    .rst_n (RST_N),
    .raw_i (CMP_OC_I),
    .lvl_o (cmp_f[1])
  );

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone decode

  assign wadr = {WB_ADR_I[7:2], 2'b00};
  assign wr   = WB_CYC_I & WB_STB_I & WB_WE_I & ~WB_ACK_O;
  assign rd   = WB_CYC_I & WB_STB_I & ~WB_WE_I & ~WB_ACK_O;
  // Partial writes keep untouched lanes by merging with the current value
  assign wdat = (rdata & ~lanes(WB_SEL_I)) | (WB_DAT_I & lanes(WB_SEL_I));
  assign w1c  = (wr && hit(wadr, `TPWFS_OFS_IRQ_STAT)) ? (WB_DAT_I & lanes(WB_SEL_I)) : 32'h0;
  assign fclr = wr && hit(wadr, `TPWFS_OFS_CTRL) && wdat[`TPWFS_CTRL_FCLR];

  always @* begin
    case (wadr)
      `TPWFS_OFS_CTRL:     rdata = {29'h0, dte_q, 1'b0, run_q};
      `TPWFS_OFS_PERIOD:   rdata = {16'h0, per_q};
      `TPWFS_OFS_DEADTIME: rdata = {22'h0, dt_q};
      `TPWFS_OFS_DUTY_A:   rdata = {16'h0, duty_q[0]};
      `TPWFS_OFS_DUTY_B:   rdata = {16'h0, duty_q[1]};
      `TPWFS_OFS_DUTY_C:   rdata = {16'h0, duty_q[2]};
      `TPWFS_OFS_OUTPUT_MASK_SETTING:  rdata = {24'h0, mask_q};
      `TPWFS_OFS_THRESH:   rdata = {18'h0, DAC_OC, 2'h0, DAC_OT};
      `TPWFS_OFS_STATUS:   rdata = {cnt_q, 10'h0, dbg2_q, dbusy_q, cmp_f, flt_q};
      `TPWFS_OFS_IRQ_STAT: rdata = {28'h0, ist_q};
      `TPWFS_OFS_IRQ_MASK: rdata = {28'h0, imsk_q};
      `TPWFS_OFS_TRIG_DLY: rdata = {16'h0, dly_q};
      default:             rdata = 32'h0;
    endcase
  end

  always @(posedge CLK) begin
    if (!RST_N) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0;
    end else begin
      WB_ACK_O <= wr | rd;
      WB_DAT_O <= rd ? rdata : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers

  always @(posedge CLK) begin
    if (!RST_N) begin
      run_q  <= 1'b0;
      dte_q  <= 1'b0;
      per_q  <= PER_RST[15:0];
      dt_q   <= DT_RST[9:0];
      mask_q <= `TPWFS_OUTPUT_MASK_SETTING_RST;
      DAC_OT <= `TPWFS_THRESH_RST;
      DAC_OC <= `TPWFS_THRESH_RST;
      imsk_q <= 4'h0;
      dly_q  <= `TPWFS_TRIG_DLY_RST;
      for (i = 0; i < 3; i = i + 1) begin
        duty_q[i] <= `TPWFS_DUTY_RST;
      end
    end else if (wr) begin
      case (wadr)
        `TPWFS_OFS_CTRL: begin
          run_q <= wdat[`TPWFS_CTRL_RUN];
          dte_q <= wdat[`TPWFS_CTRL_DTE];
        end
        `TPWFS_OFS_PERIOD:   per_q     <= wdat[15:0];
        `TPWFS_OFS_DEADTIME: dt_q      <= wdat[9:0];
        `TPWFS_OFS_DUTY_A:   duty_q[0] <= wdat[15:0];
        `TPWFS_OFS_DUTY_B:   duty_q[1] <= wdat[15:0];
        `TPWFS_OFS_DUTY_C:   duty_q[2] <= wdat[15:0];
        `TPWFS_OFS_OUTPUT_MASK_SETTING:  mask_q    <= wdat[7:0] | `TPWFS_OUTPUT_MASK_SETTING_FIX;
        `TPWFS_OFS_THRESH: begin
          DAC_OT <= wdat[5:0];
          DAC_OC <= wdat[13:8];
        end
        `TPWFS_OFS_IRQ_MASK: imsk_q <= wdat[3:0];
        `TPWFS_OFS_TRIG_DLY: dly_q  <= wdat[15:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Period counter and reload

  // Debug halt is only reported; the counter deliberately ignores it
  always @(posedge CLK) begin
    if (!RST_N) begin
      dbg1_q <= 1'b0;
      dbg2_q <= 1'b0;
    end else begin
      dbg1_q <= DBG_HALT_I;
      dbg2_q <= dbg1_q;
    end
  end

  // A stopped counter parks on its last count so the first run cycle reloads
  assign reload = run_q & (cnt_q == per_act_q - 16'h0001);

  always @(posedge CLK) begin
    if (!RST_N) begin
      cnt_q     <= PER_RST[15:0] - 16'h0001;
      per_act_q <= PER_RST[15:0];
      SYNC_TRIG <= 1'b0;
      for (j = 0; j < 3; j = j + 1) begin
        duty_act_q[j] <= `TPWFS_DUTY_RST;
      end
    end else begin
      SYNC_TRIG <= reload;
      if (!run_q) begin
        cnt_q <= per_act_q - 16'h0001;
      end else if (reload) begin
        cnt_q     <= 16'h0000;
        per_act_q <= per_q;
        for (j = 0; j < 3; j = j + 1) begin
          duty_act_q[j] <= duty_q[j];
        end
      end else begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault latch

  always @(posedge CLK) begin
    if (!RST_N) begin
      flt_q <= 2'b00;
    end else begin
      for (k = 0; k < 2; k = k + 1) begin
        if (cmp_f[k]) begin
          flt_q[k] <= 1'b1;
        end else if (fclr) begin
          flt_q[k] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Complementary pairs with dead-time

  always @* begin
    for (m = 0; m < 3; m = m + 1) begin
      ref_d[m] = (cnt_q < duty_act_q[m]);
    end
  end

  // Either side turning off restarts the gap, so dt_q + 1 cycles separate edges
  always @(posedge CLK) begin
    if (!RST_N) begin
      hs_q <= 3'b000;
      ls_q <= 3'b000;
      for (n = 0; n < 3; n = n + 1) begin
        dtc_q[n] <= DT_RST[9:0];
      end
    end else begin
      for (n = 0; n < 3; n = n + 1) begin
        if (!run_q || (|flt_q)) begin
          hs_q[n]  <= 1'b0;
          ls_q[n]  <= 1'b0;
          dtc_q[n] <= dt_q;
        end else if ((hs_q[n] & ~ref_d[n]) | (ls_q[n] & ref_d[n])) begin
          hs_q[n]  <= 1'b0;
          ls_q[n]  <= 1'b0;
          dtc_q[n] <= dt_q;
        end else if (dtc_q[n] != 10'h000) begin
          dtc_q[n] <= dtc_q[n] - 10'h001;
        end else begin
          hs_q[n] <= ref_d[n];
          ls_q[n] <= ~ref_d[n];
        end
      end
    end
  end

  always @(posedge CLK) begin
    if (!RST_N) begin
      PWM_OUT <= 6'h00;
    end else begin
      PWM_OUT <= {ls_q[2], hs_q[2], ls_q[1], hs_q[1], ls_q[0], hs_q[0]}
                 & ~mask_q[5:0] & {6{~|flt_q}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Delay trigger block

  // A new sync while the previous delay is still pending is a sequence error
  assign seq_err = reload & dte_q & dbusy_q;

  always @(posedge CLK) begin
    if (!RST_N) begin
      dbusy_q  <= 1'b0;
      dcnt_q   <= 16'h0000;
      ADC_TRIG <= 1'b0;
    end else begin
      ADC_TRIG <= 1'b0;
      if (!dte_q) begin
        dbusy_q <= 1'b0;
      end else if (reload) begin
        dbusy_q <= 1'b1;
        dcnt_q  <= dly_q;
      end else if (dbusy_q) begin
        if (dcnt_q == 16'h0000) begin
          ADC_TRIG <= 1'b1;
          dbusy_q  <= 1'b0;
        end else begin
          dcnt_q <= dcnt_q - 16'h0001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts

  assign ev = {reload, seq_err, cmp_f & ~flt_q};

  // Set wins over a simultaneous write-one-to-clear
  always @(posedge CLK) begin
    if (!RST_N) begin
      ist_q <= 4'h0;
      IRQ   <= 1'b0;
    end else begin
      ist_q <= (ist_q & ~w1c[3:0]) | ev;
      IRQ   <= |(ist_q & imsk_q);
    end
  end

endmodule // tpwfs_top
`default_nettype wire

// [tb/tb.sv]
// Purpose: Register and gate-level test of the PWM block
// Assumes: period shortened to 40 cycles, dead-time 2
// Notes:   Counts are taken over whole periods, except the 30-cycle window after the duty write
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk, rst_n, cyc, stb, we, halt, ack, sync, adct, irq, cot, coc;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, q;
  logic [5:0]  pwm, dot, doc;
  logic [1:0]  flt;
  logic [3:0]  sel, lane;
  logic [31:0] ns, na;
  logic [31:0] hi [6];
  int          errors, total_checks, shoot, wt;
  always #20 clk = ~clk;
  tpwfs_top dut_u (.CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .CMP_OT_I(cot), .CMP_OC_I(coc), .DBG_HALT_I(halt), .PWM_OUT(pwm), .DAC_OT(dot),
    .DAC_OC(doc), .SYNC_TRIG(sync), .ADC_TRIG(adct), .IRQ(irq));
  tpwfs_gate_model gate_u (.clk(clk), .gate(pwm), .trip(flt), .cmp_ot(cot), .cmp_oc(coc),
    .shoot(shoot));
  ////////////////////////////////////////////////////////////////////////////////
  task complete_run;
    if (errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("Error %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= lane;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (n >= 20) begin
      errors++;
      complete_run;
    end
  endtask
  task automatic run(input int n);
    ns = 0; na = 0;
    for (int k = 0; k < 6; k++) hi[k] = 0;
    repeat (n) begin
      @(posedge clk);
      ns += sync; na += adct;
      for (int k = 0; k < 6; k++) hi[k] += pwm[k];
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 0; rst_n = 0; cyc = 0; stb = 0; we = 0; adr = 8'h00; wdat = 32'h0; halt = 0;
    flt = 2'b00;
    sel = 4'hF; lane = 4'hF;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    wb(0, 8'h04, 0); chk(q, 32'h9C4);
    wb(0, 8'h08, 0); chk(q, 32'h19);
    wb(0, 8'h18, 0); chk(q, 32'hC0);
    wb(1, 8'h18, 0); wb(0, 8'h18, 0); chk(q, 32'hC0);
    wb(0, 8'h3C, 0); chk(q, 32'h0);
    wb(0, 8'h1C, 0); chk(q, 32'h2020);
    wb(1, 8'h1C, 32'hA15); @(posedge clk); chk({doc, dot}, 12'h295);
    lane = 4'h1; wb(1, 8'h1C, 32'h3F3F); lane = 4'hF;
    @(posedge clk); chk({doc, dot}, 12'h2BF);
    wb(1, 8'h04, 32'h28); wb(1, 8'h08, 32'h2); wb(1, 8'h0C, 32'hA);
    wb(1, 8'h10, 32'h14); wb(1, 8'h14, 32'h28); wb(1, 8'h28, 32'h8);
    halt <= 1'b1;
    wb(1, 8'h00, 32'h5); run(80); run(400);
    chk(ns, 10);
    chk(na, 10);
    chk(hi[0], 70); chk(hi[1], 270);
    chk(hi[2], 170); chk(hi[3], 170); chk(hi[4], 400); chk(hi[5], 0);
    chk(irq, 1);
    wb(0, 8'h20, 0); chk(q[5], 1);
    halt <= 1'b0;
    wb(1, 8'h28, 0); wb(1, 8'h24, 32'hF); wb(0, 8'h24, 0); chk(q[2:0], 0);
    @(posedge clk); chk(irq, 0);
    flt <= 2'b01; repeat (3) @(posedge clk); flt <= 2'b00; run(20);
    wb(0, 8'h20, 0); chk(q[1:0], 0);
    for (int i = 0; i < 2; i++) begin
      flt <= i ? 2'b10 : 2'b01; run(20); chk(pwm, 0);
      wb(0, 8'h24, 0); chk(q[i], 1);
      wb(1, 8'h00, 32'h7); run(40); chk(hi[0], 0);
      flt <= 2'b00; run(40); chk(hi[0], 0);
      wb(1, 8'h00, 32'h7); run(80); run(400); chk(hi[0], 70);
    end
    wb(1, 8'h2C, 32'h64); run(200); wb(0, 8'h24, 0); chk(q[2], 1);
    // Duty written just after a reload must wait for the next one
    wt = 0;
    do begin
      @(posedge clk);
      wt++;
    end while (sync !== 1'b1 && wt < 100);
    if (wt >= 100) begin
      errors++;
      complete_run;
    end
    wb(1, 8'h0C, 32'h28); run(30); chk(hi[0], 7);
    run(40); chk(hi[0], 29);
    chk(shoot, 0);
    complete_run;
  end
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    complete_run;
  end
endmodule // tb
`default_nettype wire

// [tb/tpwfs_gate_model.sv]
// Purpose: Power stage and comparators seen from the gate pins
// Assumes: bench commands comparator trips
// Notes:   Counts cycles where a half-bridge would short
`timescale 1ns/1ps
`default_nettype none
module tpwfs_gate_model (
  input  wire logic       clk,    // Clock
  input  wire logic [5:0] gate,   // Gate drives
  input  wire logic [1:0] trip,   // Commanded trips
  output logic            cmp_ot, // Over-temp out
  output logic            cmp_oc, // Over-current out
  output int              shoot   // Short count
);
  // Comparators drive high on a trip
  assign cmp_ot = trip[0];
  assign cmp_oc = trip[1];
  int shoot_q = 0;
  assign shoot = shoot_q;
  always @(posedge clk) begin
    if ((gate & (gate >> 1) & 6'h15) != 6'h00) begin
      shoot_q <= shoot_q + 1;
    end
  end
endmodule // tpwfs_gate_model
`default_nettype wire

// [tb/tpwfs_props.sv]
// Purpose: Port-level checks for the PWM block
// Assumes: one CLK domain, RST_N synchronous active low
// Notes:   Bound into every tpwfs_top instance
`timescale 1ns/1ps
`default_nettype none
module tpwfs_props (
  input wire logic        CLK,       // Clock
  input wire logic        RST_N,     // Reset
  input wire logic        WB_CYC_I,  // Cycle
  input wire logic        WB_STB_I,  // Strobe
  input wire logic [31:0] WB_DAT_O,  // Read data
  input wire logic        WB_ACK_O,  // Ack
  input wire logic        CMP_OT_I,  // Fault 0
  input wire logic        CMP_OC_I,  // Fault 1
  input wire logic [5:0]  PWM_OUT,   // Gates
  input wire logic [5:0]  DAC_OT,    // Threshold
  input wire logic        SYNC_TRIG, // Sync pulse
  input wire logic        ADC_TRIG   // Delayed pulse
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  pair_never_both_a: assert property ((PWM_OUT & (PWM_OUT >> 1) & 6'h15) == 6'h00)
    else $error("pair both on");
  dead_gap_a: assert property ($rose(PWM_OUT[1]) |-> !$past(PWM_OUT[0]))
    else $error("no gap before bottom on");
  sync_single_a: assert property (SYNC_TRIG |=> !SYNC_TRIG)
    else $error("sync pulse too long");
  adc_single_a: assert property (ADC_TRIG |=> !ADC_TRIG)
    else $error("delayed pulse too long");
  ack_once_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held");
  ack_next_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack late");
  dat_idle_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
    else $error("read data outside ack");
  fault_off_a: assert property ((CMP_OT_I || CMP_OC_I) [*8] |=> PWM_OUT == 6'h00)
    else $error("gates on during fault");
  reset_state_a: assert property ($rose(RST_N) |-> DAC_OT == 6'h20 && PWM_OUT == 6'h00)
    else $error("bad reset outputs");
endmodule // tpwfs_props
bind tpwfs_top tpwfs_props props_u (.CLK(CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .CMP_OT_I(CMP_OT_I),
  .CMP_OC_I(CMP_OC_I), .PWM_OUT(PWM_OUT), .DAC_OT(DAC_OT), .SYNC_TRIG(SYNC_TRIG),
  .ADC_TRIG(ADC_TRIG));
`default_nettype wire
